// ### hdl/spd_pkg.sv
// constants for the synthesizer post-divider output stage
// assumes a byte-wide register port and tick inputs on core_clk
package spd_pkg;
	localparam logic [7:0] S2D_ADDR_HI = 8'hA1;
	localparam logic [7:0] S2D_ADDR_MID = 8'hA2;
	localparam logic [7:0] S2D_ADDR_LO = 8'hA3;
	localparam logic [7:0] S3A_ADDR_HI = 8'hA4;
	localparam logic [7:0] S3A_ADDR_MID = 8'hA5;
	localparam logic [7:0] S3A_ADDR_LO = 8'hA6;
	localparam logic [23:0] CTL_RESET = 24'h000000;
	localparam int MODE_MSB = 23;
	localparam int MODE_LSB = 20;
	localparam logic [3:0] MODE_SPECIAL = 4'hF;
	localparam int EDGE_TYPE_BIT = 19;
	localparam int POLARITY_BIT = 18;
	localparam int SRC_MSB = 17;
	localparam int SRC_LSB = 16;
	localparam int RATE_MSB = 15;
	localparam logic [1:0] S2D_LF_SEL = 2'h3;
	localparam logic [1:0] S3A_LF_SEL = 2'h0;
	localparam int PERIOD_W = 16;

	typedef enum logic [2:0] {
		SPD_DIV = 3'b001,
		SPD_LF = 3'b010,
		SPD_FRM = 3'b100
	} spd_mode_e;

	function automatic spd_mode_e spd_decode(input logic [23:0] w, input logic [1:0] lfSel);
		spd_mode_e m;
		if (w[MODE_MSB:MODE_LSB] != MODE_SPECIAL) begin
			m = SPD_DIV;
		end else if (w[SRC_MSB:SRC_LSB] == lfSel) begin
			m = SPD_LF;
		end else begin
			m = SPD_FRM;
		end
		return m;
	endfunction
endpackage

// ### hdl/spd_gen_if.sv
// signals between the register side and one output generator
// assumes both ends run on core_clk
`timescale 1ns/1ps
interface spd_gen_if;
	logic [23:0] ctrl;
	logic restart;
	logic outTick;
	logic baseTick;
	logic [3:0] srcTick;
	logic genOut;
	modport top(output ctrl, output restart, output outTick, output baseTick,
		output srcTick, input genOut);
	modport gen(input ctrl, input restart, input outTick, input baseTick,
		input srcTick, output genOut);
endinterface

// ### hdl/spd_frame_gen.sv
// one post-divider output: divider, low-frequency clock or frame pulse
// assumes ticks are one-cycle pulses on core_clk, one per source period
`timescale 1ns/1ps
module spd_frame_gen #(
	parameter logic [1:0] LF_SEL = 2'h3,
	parameter int PW = 16
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	spd_gen_if.gen g
);
	logic [23:0] cfg_r, cfg_nxt;
	logic [23:0] cnt_r, cnt_nxt;
	logic [PW-1:0] phase_r, phase_nxt;
	logic [PW-1:0] period_r, period_nxt;
	logic pend_r, pend_nxt;
	logic out_r, out_nxt;
	spd_pkg::spd_mode_e mode;
	logic tick;
	logic [23:0] ratio;
	logic [23:0] last;
	logic [23:0] half;
	logic wrap;
	logic apply;
	logic active;
	logic [PW-1:0] halfPer;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		mode = spd_pkg::spd_decode(cfg_r, LF_SEL);
		case (mode)
			spd_pkg::SPD_DIV: tick = g.outTick;
			spd_pkg::SPD_LF: tick = g.baseTick;
			spd_pkg::SPD_FRM: tick = g.srcTick[cfg_r[spd_pkg::SRC_MSB:spd_pkg::SRC_LSB]];
			default: tick = 1'b0;
		endcase
		if (mode == spd_pkg::SPD_DIV) begin
			ratio = cfg_r;
		end else begin
			ratio = {8'h00, cfg_r[spd_pkg::RATE_MSB:0]};
		end
		last = ratio - 24'h000001;
		half = (ratio + 24'h000001) >> 1;
		halfPer = period_r >> 1;
		wrap = tick && (cnt_r >= last);
		apply = pend_r && (wrap || ratio == 24'h000000);
		pend_nxt = g.restart || (pend_r && !apply);
		cfg_nxt = apply ? g.ctrl : cfg_r;
		if (apply || wrap) begin
			cnt_nxt = 24'h000000;
		end else if (tick) begin
			cnt_nxt = cnt_r + 24'h000001;
		end else begin
			cnt_nxt = cnt_r;
		end
		// core cycles per source period, for the centred boundary
		if (tick) begin
			phase_nxt = '0;
			period_nxt = phase_r + 1'b1;
		end else begin
			phase_nxt = (&phase_r) ? phase_r : phase_r + 1'b1;
			period_nxt = period_r;
		end
		if (mode == spd_pkg::SPD_FRM) begin
			if (cfg_r[spd_pkg::EDGE_TYPE_BIT]) begin
				active = (cnt_r == 24'h000000);
			end else begin
				active = ((cnt_r == last) && (phase_r >= halfPer))
					|| ((cnt_r == 24'h000000) && (phase_r < halfPer));
			end
		end else begin
			active = (cnt_r < half);
		end
		if (ratio == 24'h000000) begin
			active = 1'b0;
		end
		out_nxt = active ^ ((mode == spd_pkg::SPD_FRM) && cfg_r[spd_pkg::POLARITY_BIT]);
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cfg_r <= spd_pkg::CTL_RESET;
			cnt_r <= '0;
			phase_r <= '0;
			period_r <= '0;
			pend_r <= 1'b0;
			out_r <= 1'b0;
		end else if (clkEn) begin
			cfg_r <= cfg_nxt;
			cnt_r <= cnt_nxt;
			phase_r <= phase_nxt;
			period_r <= period_nxt;
			pend_r <= pend_nxt;
			out_r <= out_nxt;
		end
	end

	assign g.genOut = out_r;
endmodule

// ### hdl/spd_top.sv
// register port and two post-divider outputs (synth 2 D, synth 3 A)
// assumes synthesizer clocks arrive as one-cycle ticks on core_clk
`timescale 1ns/1ps
module spd_top (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	input wire logic s2OutTick,
	input wire logic s2BaseTick,
	input wire logic s2PdATick,
	input wire logic s2PdBTick,
	input wire logic s2PdCTick,
	input wire logic s3OutTick,
	input wire logic s3BaseTick,
	input wire logic s3PdBTick,
	input wire logic s3PdCTick,
	input wire logic s3PdDTick,
	output logic s2dOut,
	output logic s3aOut
);
	logic [23:0] s2Ctl_r, s2Ctl_nxt;
	logic [23:0] s3Ctl_r, s3Ctl_nxt;
	logic s2Restart_r, s2Restart_nxt;
	logic s3Restart_r, s3Restart_nxt;
	logic [7:0] rdData_r, rdData_nxt;

	spd_gen_if s2If ();
	spd_gen_if s3If ();

	// ----------------------------------------
	// register port
	// ----------------------------------------
	function automatic logic [23:0] put_byte(input logic [23:0] w, input logic [7:0] a,
		input logic [7:0] base, input logic [7:0] d);
		logic [23:0] r;
		r = w;
		if (a == base) begin
			r[23:16] = d;
		end else if (a == base + 8'h01) begin
			r[15:8] = d;
		end else if (a == base + 8'h02) begin
			r[7:0] = d;
		end
		return r;
	endfunction

	always_comb begin
		s2Ctl_nxt = s2Ctl_r;
		s3Ctl_nxt = s3Ctl_r;
		s2Restart_nxt = 1'b0;
		s3Restart_nxt = 1'b0;
		rdData_nxt = rdData_r;
		if (regWrEn) begin
			s2Ctl_nxt = put_byte(s2Ctl_r, regAddr, spd_pkg::S2D_ADDR_HI, regWrData);
			s3Ctl_nxt = put_byte(s3Ctl_r, regAddr, spd_pkg::S3A_ADDR_HI, regWrData);
			s2Restart_nxt = (regAddr == spd_pkg::S2D_ADDR_LO);
			s3Restart_nxt = (regAddr == spd_pkg::S3A_ADDR_LO);
		end
		if (regRdEn) begin
			case (regAddr)
				spd_pkg::S2D_ADDR_HI: rdData_nxt = s2Ctl_r[23:16];
				spd_pkg::S2D_ADDR_MID: rdData_nxt = s2Ctl_r[15:8];
				spd_pkg::S2D_ADDR_LO: rdData_nxt = s2Ctl_r[7:0];
				spd_pkg::S3A_ADDR_HI: rdData_nxt = s3Ctl_r[23:16];
				spd_pkg::S3A_ADDR_MID: rdData_nxt = s3Ctl_r[15:8];
				spd_pkg::S3A_ADDR_LO: rdData_nxt = s3Ctl_r[7:0];
				default: rdData_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s2Ctl_r <= spd_pkg::CTL_RESET;
			s3Ctl_r <= spd_pkg::CTL_RESET;
			s2Restart_r <= 1'b0;
			s3Restart_r <= 1'b0;
			rdData_r <= 8'h00;
		end else if (clkEn) begin
			s2Ctl_r <= s2Ctl_nxt;
			s3Ctl_r <= s3Ctl_nxt;
			s2Restart_r <= s2Restart_nxt;
			s3Restart_r <= s3Restart_nxt;
			rdData_r <= rdData_nxt;
		end
	end

	// ----------------------------------------
	// source routing
	// ----------------------------------------
	assign s2If.ctrl = s2Ctl_r;
	assign s2If.restart = s2Restart_r;
	assign s2If.outTick = s2OutTick;
	assign s2If.baseTick = s2BaseTick;
	assign s2If.srcTick = {1'b0, s2PdCTick, s2PdBTick, s2PdATick};
	assign s3If.ctrl = s3Ctl_r;
	assign s3If.restart = s3Restart_r;
	assign s3If.outTick = s3OutTick;
	assign s3If.baseTick = s3BaseTick;
	assign s3If.srcTick = {s3PdDTick, s3PdCTick, s3PdBTick, 1'b0};

	spd_frame_gen #(.LF_SEL(spd_pkg::S2D_LF_SEL), .PW(spd_pkg::PERIOD_W)) s2Gen (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.g(s2If.gen)
	);

	spd_frame_gen #(.LF_SEL(spd_pkg::S3A_LF_SEL), .PW(spd_pkg::PERIOD_W)) s3Gen (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.g(s3If.gen)
	);

	assign regRdData = rdData_r;
	assign s2dOut = s2If.genOut;
	assign s3aOut = s3If.genOut;
endmodule

// ### test/spd_tick_src.sv
// synthesizer tick source for the post-divider stage
// assumes core_clk domain, period of at least 2 cycles
`timescale 1ns/1ps
module spd_tick_src (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] per,
	output logic tick
);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	always_comb begin
		cnt_nxt = (cnt_r + 8'h01 >= per) ? 8'h00 : cnt_r + 8'h01;
	end
	always_ff @(posedge core_clk) begin
		cnt_r <= sys_rst ? 8'h00 : cnt_nxt;
	end
	assign tick = cnt_r == 8'h00 && !sys_rst;
endmodule

// ### test/spd_monitor.sv
// checker on the register port and both output levels
// assumes it is bound into spd_top
`timescale 1ns/1ps
module spd_monitor (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic [7:0] regRdData,
	input wire logic s2dOut,
	input wire logic s3aOut
);
	logic [7:0] shadow_r [6];
	logic [1:0] armed_r;
	logic inMap;
	logic [7:0] shByte;
	assign inMap = regAddr >= 8'hA1 && regAddr <= 8'hA6;
	assign shByte = inMap ? shadow_r[regAddr - 8'hA1] : 8'h00;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < 6; i++) begin
				shadow_r[i] <= 8'h00;
			end
			armed_r <= 2'h0;
		end else if (regWrEn && clkEn && inMap) begin
			shadow_r[regAddr - 8'hA1] <= regWrData;
			armed_r <= armed_r | {regAddr == 8'hA6, regAddr == 8'hA3};
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	chk_rst_out_low: assert property ($fell(sys_rst) |-> !s2dOut && !s3aOut && regRdData == 8'h00)
		else $error("outputs not clear after reset");
	chk_freeze_outputs: assert property (!clkEn |=> $stable(s2dOut) && $stable(s3aOut))
		else $error("output moved while frozen");
	chk_freeze_read: assert property (!clkEn |=> $stable(regRdData))
		else $error("read data moved while frozen");
	chk_read_hold: assert property ($changed(regRdData) |-> $past(regRdEn && clkEn || sys_rst))
		else $error("read data changed without a read");
	chk_read_data: assert property (regRdEn && clkEn |=> regRdData == $past(shByte))
		else $error("read data differs from written byte");
	chk_s2_no_glitch: assert property ($changed(s2dOut) |=> $stable(s2dOut))
		else $error("one-cycle pulse on output D");
	chk_s3_no_glitch: assert property ($changed(s3aOut) |=> $stable(s3aOut))
		else $error("one-cycle pulse on output A");
	chk_idle_low: assert property ((armed_r[0] || !s2dOut) && (armed_r[1] || !s3aOut))
		else $error("output active before any word");
endmodule
bind spd_top spd_monitor i_spd_monitor (.core_clk, .sys_rst, .clkEn, .regWrEn, .regRdEn,
	.regAddr, .regWrData, .regRdData, .s2dOut, .s3aOut);

// ### test/spd_top_tb.sv
// self-checking bench for the post-divider output stage
// assumes spd_top, spd_tick_src and spd_monitor are compiled first
`timescale 1ns/1ps
module spd_top_tb;
	logic core_clk, sys_rst, clkEn, regWrEn, regRdEn, tick, tickAlt, s2dOut, s3aOut, obs, rdPend;
	logic [7:0] regAddr, regWrData, regRdData, per;
	logic [7:0] qByte[$];
	int qRun[$];
	int n_fail, checked, seed, run, r;
	initial begin
		core_clk = 1'h0;
		forever #10 core_clk = ~core_clk;
	end
	spd_tick_src i_spd_tick_src (.core_clk, .sys_rst, .per, .tick);
	// sources no scenario picks run at another rate, so a wrong pick shows in the run length
	spd_tick_src i_spd_tick_src_alt (.core_clk, .sys_rst, .per(8'h05), .tick(tickAlt));
	spd_top i_spd_top (.core_clk, .sys_rst, .clkEn, .regWrEn, .regRdEn, .regAddr, .regWrData,
		.regRdData, .s2OutTick(tick), .s2BaseTick(tick), .s2PdATick(tick), .s2PdBTick(tick),
		.s2PdCTick(tickAlt), .s3OutTick(tickAlt), .s3BaseTick(tick), .s3PdBTick(tickAlt),
		.s3PdCTick(tickAlt), .s3PdDTick(tick), .s2dOut, .s3aOut);
	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic cmpByte(input string s, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %0h got %0h", s, e, g);
		end
	endtask
	task automatic cmpRun(input string s, input int e, input int g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %0d got %0d", s, e, g);
		end
	endtask
	task automatic wrWord(input logic [7:0] a, input logic [23:0] w);
		for (int i = 0; i < 3; i++) begin
			@(posedge core_clk);
			regWrEn <= 1'h1;
			regAddr <= a + 8'(i);
			regWrData <= w[23 - 8 * i -: 8];
		end
		@(posedge core_clk);
		regWrEn <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		regRdEn <= 1'h1;
		regAddr <= a;
		qByte.push_back(e);
		@(posedge core_clk);
		regRdEn <= 1'h0;
	endtask
	// skip settling pulses, then note the length of the next active run
	task automatic expRun(input int v);
		int k;
		int n;
		logic p;
		n = 0;
		p = 1'h1;
		for (k = 0; k < 4000 && n < 3; k++) begin
			@(posedge core_clk);
			n += int'((obs ? s3aOut : s2dOut) === 1'h1 && !p);
			p = obs ? s3aOut : s2dOut;
		end
		qRun.push_back(v);
		for (k = 0; k < 4000 && qRun.size() != 0; k++) begin
			@(posedge core_clk);
		end
		if (n < 3 || qRun.size() != 0) begin
			n_fail++;
			tally_and_finish();
		end
		$display("test done, run %0d", v);
	endtask
	always @(posedge core_clk) begin
		if (rdPend) begin
			cmpByte("regRdData", qByte.pop_front(), regRdData);
		end
		rdPend = regRdEn && clkEn;
		if ((obs ? s3aOut : s2dOut) === 1'h1) begin
			run++;
		end else begin
			if (run != 0 && qRun.size() != 0) begin
				cmpRun("run", qRun.pop_front(), run);
			end
			run = 0;
		end
	end
	initial begin
		{sys_rst, clkEn, regWrEn, regRdEn, obs, rdPend} = 6'h30;
		{regAddr, regWrData, per} = {16'h0000, 8'h03};
		{seed, run, n_fail, checked} = {32'd61, 96'd0};
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'h0;
		for (int i = 0; i < 7; i++) begin
			rd(8'hA1 + 8'(i), 8'h00);
		end
		$display("test done, reset values");
		r = 2 + {$random(seed)} % 30;
		wrWord(8'hA1, 24'(r));
		rd(8'hA3, 8'(r));
		expRun((r + 1) / 2 * 3);
		@(posedge core_clk);
		clkEn <= 1'h0;
		// strobes while frozen must leave the word and the read data alone
		@(posedge core_clk);
		{regWrEn, regRdEn} <= 2'h3;
		regAddr <= 8'hA2;
		regWrData <= 8'(~r);
		@(posedge core_clk);
		{regWrEn, regRdEn} <= 2'h0;
		repeat (4) @(posedge core_clk);
		clkEn <= 1'h1;
		rd(8'hA2, 8'h00);
		$display("test done, freeze");
		wrWord(8'hA1, 24'hF30004);
		expRun(6);
		wrWord(8'hA1, 24'hF80005);
		expRun(3);
		wrWord(8'hA1, 24'hFC0005);
		expRun(12);
		per <= 8'h04;
		wrWord(8'hA1, 24'hF10005);
		expRun(4);
		obs <= 1'h1;
		wrWord(8'hA4, 24'hF00006);
		expRun(12);
		wrWord(8'hA4, 24'hFB0003);
		expRun(4);
		@(posedge core_clk);
		sys_rst <= 1'h1;
		@(posedge core_clk);
		sys_rst <= 1'h0;
		rd(8'hA6, 8'h00);
		rd(8'hA6, 8'h00);
		repeat (3) @(posedge core_clk);
		$display("test done, mid-run reset");
		tally_and_finish();
	end
endmodule
